// [rtl/opregs_pkg.sv]
package opregs_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses from operational base)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_PAGE_SIZES   = 8'h08;
    localparam logic [7:0]  OFS_NOTIF_FILTER = 8'h14;
    localparam logic [7:0]  OFS_CRC_LO       = 8'h18;
    localparam logic [7:0]  OFS_CRC_HI       = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h20;
    localparam logic [7:0]  OFS_IRQ_MASK     = 8'h24;
    localparam logic [7:0]  OFS_DOORBELL     = 8'h28;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          BIT_RCS          = 0;
    localparam int          BIT_STOP         = 1;
    localparam int          BIT_ABORT        = 2;
    localparam int          BIT_RUNNING      = 3;
    localparam int          PTR_LO_LSB       = 6;
    localparam int          PAGE_FIELD_W     = 16;
    localparam int          PAGE_MAX_BIT     = 15;
    localparam int          FUNC_WAKE_TYPE   = 1;
    localparam int          IRQ_W            = 3;
    localparam int          IRQ_NOTIF        = 0;
    localparam int          IRQ_STOPPED      = 1;
    localparam int          IRQ_ABORTED      = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_NOTIF_FILTER = 16'h0000;
    localparam logic [15:0] DEF_PAGE_SIZES   = 16'h0001;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;
endpackage : opregs_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module pin_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin in, clean level out
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    always_comb begin
        st_d     = st_q;
        st_d.s1  = pin_i;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;
endmodule : pin_sync

// [rtl/notif_gate.sv]
`timescale 1ns/1ps
// gates an incoming notification packet by its type against enable bits
module notif_gate
    import opregs_pkg::*;
#(
    parameter int TYPES = 16
) (
    // enable bits and packet
    input  wire logic [TYPES-1:0]         enable_i,
    input  wire logic                     pkt_valid_i,
    input  wire logic [$clog2(TYPES)-1:0] pkt_type_i,
    // result
    output logic                          event_o
);
    assign event_o = pkt_valid_i && enable_i[pkt_type_i];
endmodule : notif_gate

// [rtl/page_notify_cmdring_regs.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Functional notes
// - bits 15:0 of the page size register are read-only and bit n means 2^(n+12) byte pages.
// - a virtual function reads its chosen system page size, function zero the default size.
// - no page size bit above the one for 128M pages may ever be set.
// - the notification filter holds 16 enable bits, bit index equal to notification type.
// - a received notification whose type is enabled raises an event, others raise none.
// - the notification filter reads all zeros after reset.
// - enable bit 1 gates function wake notifications.
// - the command ring control register is 64 bits at offset 18h and resets to zero.
// - it holds the dequeue pointer, bits 31:6 in the low word and the upper half in the high word.
// - bit 0 cycle state, bit 1 stop, bit 2 abort, bit 3 running, bits 5:4 reserved.
// - running is read-only, sets on doorbell while run is on, clears on stop, abort or run off.
// - writing one to stop halts after the current command and posts a stopped event.
// - writing one to abort ends the command at once, stops and posts a stopped event.
// - cycle state writes are ignored while running, kept for the next fetch, read zero.
// ----------------------------------------------------------------
module page_notify_cmdring_regs
    import opregs_pkg::*;
#(
    parameter int          NTYPES       = 16,
    parameter logic [15:0] PF_PAGE_SIZE = DEF_PAGE_SIZES
) (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone slave
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [7:0]                adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    // function selection
    input  wire logic                      is_vf_i,
    input  wire logic [15:0]               vf_page_size_i,
    // controller run state and ring engine
    input  wire logic                      run_i,
    input  wire logic                      cmd_done_i,
    input  wire logic                      ptr_adv_i,
    input  wire logic [63:0]               ptr_next_i,
    input  wire logic                      ccs_next_i,
    // notification packets from the link
    input  wire logic                      notif_valid_i,
    input  wire logic [$clog2(NTYPES)-1:0] notif_type_i,
    // ring engine controls and events
    output logic                           ring_running_o,
    output logic                           ring_start_o,
    output logic                           stop_req_o,
    output logic                           abort_req_o,
    output logic                           stopped_event_o,
    output logic                           notif_event_o,
    output logic [63:0]                    dequeue_ptr_o,
    output logic                           cycle_state_o,
    output logic                           irq_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RING_IDLE, RING_RUN, RING_STOPPING} ring_e;

    typedef struct packed {
        logic [31:0]        dat;
        logic               ack;
        logic [NTYPES-1:0]  filter;
        logic [63:6]        ptr;
        logic               ring_cycle_state;
        ring_e              ring;
        logic               running;
        logic               start;
        logic               stop_pend;
        logic               abort_pend;
        logic               stopped_ev;
        logic               notif_ev;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic               irq;
        logic [15:0]        page_sizes;
    } regs_s;

    regs_s st_q;
    regs_s st_d;

    logic notif_hit;
    logic run_sync;

    notif_gate #(
        .TYPES       (NTYPES)
    ) u_gate (
        .enable_i    (st_q.filter),
        .pkt_valid_i (notif_valid_i),
        .pkt_type_i  (notif_type_i),
        .event_o     (notif_hit)
    );

    pin_sync u_run_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (run_i),
        .level_o (run_sync)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic               req;
    logic               wr;
    logic               full_word;
    logic [IRQ_W-1:0]   ev_set;
    logic [15:0]        page_src;

    always_comb begin
        st_d      = st_q;
        req       = cyc_i && stb_i && !st_q.ack;
        wr        = req && we_i;
        full_word = (sel_i == 4'hF);
        ev_set    = '0;

        st_d.ack        = req;
        st_d.dat        = RST_WORD;
        st_d.start      = 1'b0;
        st_d.stopped_ev = 1'b0;
        st_d.notif_ev   = notif_hit;

        page_src = is_vf_i ? vf_page_size_i : PF_PAGE_SIZE;
        st_d.page_sizes = page_src & 16'((32'd1 << (PAGE_MAX_BIT + 1)) - 32'd1);

        // reads; reserved and unmapped return zero
        if (req && !we_i) begin
            case (adr_i)
                OFS_PAGE_SIZES:   st_d.dat = {16'h0000, st_q.page_sizes};
                OFS_NOTIF_FILTER: st_d.dat = {{(32-NTYPES){1'b0}}, st_q.filter};
                OFS_CRC_LO:       st_d.dat = {st_q.ptr[31:6], 2'b00,
                                              (st_q.ring != RING_IDLE), 3'b000};
                OFS_CRC_HI:       st_d.dat = st_q.ptr[63:32];
                OFS_IRQ_STATUS:   st_d.dat = {{(32-IRQ_W){1'b0}}, st_q.irq_stat};
                OFS_IRQ_MASK:     st_d.dat = {{(32-IRQ_W){1'b0}}, st_q.irq_mask};
                default:          st_d.dat = RST_WORD;
            endcase
        end

        // writes
        if (wr) begin
            case (adr_i)
                OFS_NOTIF_FILTER: begin
                    if (full_word) begin
                        st_d.filter = dat_i[NTYPES-1:0];
                    end
                end
                OFS_CRC_LO: begin
                    if (st_q.ring == RING_IDLE) begin
                        st_d.ptr[31:6] = dat_i[31:6];
                        if (sel_i[0]) begin
                            st_d.ring_cycle_state = dat_i[BIT_RCS];
                        end
                    end else if (sel_i[0]) begin
                        if (dat_i[BIT_ABORT]) begin
                            st_d.abort_pend = 1'b1;
                            st_d.ring       = RING_STOPPING;
                        end else if (dat_i[BIT_STOP]) begin
                            st_d.stop_pend = 1'b1;
                            st_d.ring      = RING_STOPPING;
                        end
                    end
                end
                OFS_CRC_HI: begin
                    if (st_q.ring == RING_IDLE) begin
                        st_d.ptr[63:32] = dat_i;
                    end
                end
                OFS_IRQ_MASK:  st_d.irq_mask = dat_i[IRQ_W-1:0];
                OFS_DOORBELL: begin
                    if (run_sync && st_q.ring == RING_IDLE) begin
                        st_d.ring  = RING_RUN;
                        st_d.start = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // ring engine follows the dequeue pointer as it consumes commands
        if (ptr_adv_i && st_q.ring != RING_IDLE) begin
            st_d.ptr = ptr_next_i[63:6];
            st_d.ring_cycle_state = ccs_next_i;
        end

        // stop completes after current command; abort completes at once
        if (st_q.ring == RING_STOPPING && (st_q.abort_pend || cmd_done_i)) begin
            st_d.ring       = RING_IDLE;
            st_d.stop_pend  = 1'b0;
            st_d.abort_pend = 1'b0;
            st_d.stopped_ev = 1'b1;
            ev_set[IRQ_STOPPED] = st_q.stop_pend && !st_q.abort_pend;
            ev_set[IRQ_ABORTED] = st_q.abort_pend;
        end
        if (!run_sync) begin
            st_d.ring       = RING_IDLE;
            st_d.stop_pend  = 1'b0;
            st_d.abort_pend = 1'b0;
            st_d.start      = 1'b0;
        end

        ev_set[IRQ_NOTIF] = notif_hit;

        // sticky status: set beats a write-one clear in the same cycle
        if (wr && adr_i == OFS_IRQ_STATUS) begin
            st_d.irq_stat = st_q.irq_stat & ~dat_i[IRQ_W-1:0];
        end
        st_d.irq_stat = st_d.irq_stat | ev_set;
        st_d.running  = (st_d.ring != RING_IDLE);
        st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q        <= '0;
            st_q.filter <= NTYPES'(RST_NOTIF_FILTER);
            st_q.ring   <= RING_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dat_o           = st_q.dat;
    assign ack_o           = st_q.ack;
    assign ring_running_o  = st_q.running;
    assign ring_start_o    = st_q.start;
    assign stop_req_o      = st_q.stop_pend;
    assign abort_req_o     = st_q.abort_pend;
    assign stopped_event_o = st_q.stopped_ev;
    assign notif_event_o   = st_q.notif_ev;
    assign dequeue_ptr_o   = {st_q.ptr, 6'b00_0000};
    assign cycle_state_o   = st_q.ring_cycle_state;
    assign irq_o           = st_q.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_notif_event_gated: assert property (notif_valid_i && !st_q.filter[notif_type_i]
        |=> !notif_event_o) else $error("event from disabled notification type");
    a_wake_enabled_event: assert property (notif_valid_i && notif_type_i == 4'd1
        && st_q.filter[FUNC_WAKE_TYPE] |=> notif_event_o)
        else $error("function wake event missing");
    a_page_upper_zero: assert property (ack_o && $past(adr_i) == OFS_PAGE_SIZES
        && !$past(we_i) |-> dat_o[31:16] == 16'h0000)
        else $error("page size reserved bits set");
    a_page_vf_select: assert property (is_vf_i && $stable(vf_page_size_i)
        |=> st_q.page_sizes == vf_page_size_i) else $error("vf page size wrong");
    a_crc_flags_zero: assert property (ack_o && $past(adr_i) == OFS_CRC_LO
        && !$past(we_i) |-> dat_o[2:0] == 3'b000 && dat_o[5:4] == 2'b00)
        else $error("write-only command flags read back");
    a_rcs_hold_running: assert property (ring_running_o && !ptr_adv_i
        |=> $stable(cycle_state_o)) else $error("cycle state changed while running");
    a_stop_idle_ignored: assert property (!ring_running_o && !stop_req_o
        |=> !stop_req_o && !abort_req_o) else $error("stop accepted while idle");
    a_abort_stops_fast: assert property (abort_req_o && run_sync
        |=> !ring_running_o && stopped_event_o) else $error("abort did not stop");
    a_run_off_clears: assert property (!run_sync |=> !ring_running_o)
        else $error("ring running without run");
    a_filter_word_only: assert property (cyc_i && stb_i && we_i && !ack_o
        && adr_i == OFS_NOTIF_FILTER && sel_i != 4'hF |=> $stable(st_q.filter))
        else $error("filter took a partial write");

    c_notif_event:   cover property (notif_event_o);
    c_ring_start:    cover property (ring_start_o);
    c_stop_complete: cover property (stop_req_o ##[1:20] stopped_event_o);
    c_irq_raised:    cover property (irq_o);
endmodule : page_notify_cmdring_regs

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    import opregs_pkg::*;
    // --------------------------------------------------------
    // stimulus, design and result queues
    // --------------------------------------------------------
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic        ack_o, is_vf_i = 1'b0, run_i = 1'b0, cmd_done_i = 1'b0;
    logic [15:0] vf_page_size_i = 16'h0000, v, f;
    logic        notif_valid_i = 1'b0, nv_d = 1'b0;
    logic [3:0]  notif_type_i = 4'h0;
    logic        ring_running_o, ring_start_o, stop_req_o, abort_req_o;
    logic        stopped_event_o, notif_event_o, cycle_state_o, irq_o;
    logic [63:0] dequeue_ptr_o;
    logic [31:0] p, ph, exp_q[$], msk_q[$];
    logic        ev_q[$];
    int          seed, mismatches = 0, num_checks = 0;

    page_notify_cmdring_regs u_page_notify_cmdring_regs (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .is_vf_i(is_vf_i), .vf_page_size_i(vf_page_size_i), .run_i(run_i),
        .cmd_done_i(cmd_done_i), .ptr_adv_i(1'b0), .ptr_next_i(64'h0000_0000_0000_0000),
        .ccs_next_i(1'b0), .notif_valid_i(notif_valid_i), .notif_type_i(notif_type_i),
        .ring_running_o(ring_running_o), .ring_start_o(ring_start_o),
        .stop_req_o(stop_req_o), .abort_req_o(abort_req_o),
        .stopped_event_o(stopped_event_o), .notif_event_o(notif_event_o),
        .dequeue_ptr_o(dequeue_ptr_o), .cycle_state_o(cycle_state_o), .irq_o(irq_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // read notes its expected word; the monitor compares it at ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] m);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s;
        dat_i <= w ? d : 32'h0000_0000;
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            $display("MISMATCH t=%0t bus answer timed out", $time);
        end
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF, ALL);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        wb(1'b0, a, e, 4'hF, m);
    endtask : rd

    task automatic notify(input logic [3:0] t, input logic e);
        @(posedge clk_i);
        notif_valid_i <= 1'b1; notif_type_i <= t;
        ev_q.push_back(e);
        @(posedge clk_i);
        notif_valid_i <= 1'b0;
    endtask : notify

    task automatic wait_stop;
        int k;
        k = 0;
        while (stopped_event_o !== 1'b1 && k < 10) begin
            @(posedge clk_i);
            k++;
        end
        check({31'h0, k < 10}, 32'h0000_0001);
        @(posedge clk_i);
        check({31'h0, ring_running_o}, 32'h0000_0000);
    endtask : wait_stop

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
            check(dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
        if (nv_d && ev_q.size() > 0) begin
            check({31'h0, notif_event_o}, {31'h0, ev_q.pop_front()});
        end
        nv_d <= notif_valid_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end

    // --------------------------------------------------------
    // tests
    // --------------------------------------------------------
    initial begin
        seed = 32'h55a7;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_PAGE_SIZES, {16'h0000, DEF_PAGE_SIZES}, ALL);
        rd(OFS_NOTIF_FILTER, 32'h0000_0000, ALL);
        rd(OFS_CRC_LO, 32'h0000_0000, ALL);
        rd(OFS_CRC_HI, 32'h0000_0000, ALL);
        wr(OFS_PAGE_SIZES, ALL);
        rd(OFS_PAGE_SIZES, {16'h0000, DEF_PAGE_SIZES}, ALL);
        v = 16'($random(seed));
        is_vf_i <= 1'b1; vf_page_size_i <= v;
        rd(OFS_PAGE_SIZES, {16'h0000, v}, ALL);
        is_vf_i <= 1'b0;
        $display("test page sizes done");
        wr(OFS_NOTIF_FILTER, ALL);
        rd(OFS_NOTIF_FILTER, 32'h0000_FFFF, ALL);
        for (int i = 0; i < 3; i++) begin
            f = (i == 0) ? 16'h0002 : 16'($random(seed));
            wr(OFS_NOTIF_FILTER, {16'h0000, f});
            for (int t = 0; t < 16; t++) begin
                notify(4'(t), f[t]);
            end
        end
        wb(1'b1, OFS_NOTIF_FILTER, 32'h0000_FFFF, 4'h1, ALL);
        rd(OFS_NOTIF_FILTER, {16'h0000, f}, ALL);
        rd(OFS_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(OFS_IRQ_STATUS, 32'h0000_0007);
        rd(OFS_IRQ_STATUS, 32'h0000_0000, 32'h0000_0007);
        $display("test notification filter done");
        p = $random(seed);
        ph = $random(seed);
        wr(OFS_CRC_LO, {p[31:6], 6'b110001});
        wr(OFS_CRC_HI, ph);
        @(posedge clk_i);
        check(dequeue_ptr_o[31:0], {p[31:6], 6'h00});
        check(dequeue_ptr_o[63:32], ph);
        check({31'h0, cycle_state_o}, 32'h0000_0001);
        rd(OFS_CRC_LO, 32'h0000_0000, 32'h0000_003F);
        wr(OFS_CRC_LO, {p[31:6], 6'b000111});
        @(posedge clk_i);
        check({31'h0, stop_req_o | abort_req_o}, 32'h0000_0000);
        run_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wr(OFS_DOORBELL, 32'h0000_0001);
        check({31'h0, ring_start_o}, 32'h0000_0001);
        @(posedge clk_i);
        check({31'h0, ring_running_o}, 32'h0000_0001);
        rd(OFS_CRC_LO, 32'h0000_0008, 32'h0000_003F);
        wr(OFS_CRC_LO, 32'h0000_0000);
        @(posedge clk_i);
        check({31'h0, cycle_state_o}, 32'h0000_0001);
        check(dequeue_ptr_o[31:0], {p[31:6], 6'h00});
        wr(OFS_CRC_LO, 32'h0000_0002);
        @(posedge clk_i);
        check({30'h0, stop_req_o, ring_running_o}, 32'h0000_0003);
        cmd_done_i <= 1'b1;
        @(posedge clk_i);
        cmd_done_i <= 1'b0;
        wait_stop();
        wr(OFS_DOORBELL, 32'h0000_0001);
        wr(OFS_CRC_LO, 32'h0000_0004);
        check({31'h0, abort_req_o}, 32'h0000_0001);
        wait_stop();
        $display("test command ring done");
        rd(OFS_IRQ_STATUS, 32'h0000_0006, 32'h0000_0007);
        wr(OFS_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0000_0001);
        wr(OFS_IRQ_STATUS, 32'h0000_0002);
        rd(OFS_IRQ_STATUS, 32'h0000_0004, 32'h0000_0007);
        wr(OFS_IRQ_MASK, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0000_0000);
        wr(OFS_IRQ_STATUS, 32'h0000_0004);
        $display("test interrupt done");
        wr(OFS_DOORBELL, 32'h0000_0001);
        @(posedge clk_i);
        run_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({31'h0, ring_running_o}, 32'h0000_0000);
        rd(OFS_IRQ_STATUS, 32'h0000_0000, 32'h0000_0007);
        rd(8'h30, 32'h0000_0000, ALL);
        $display("test run clear done");
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule : tb
